// File: verilog/bps_pkg.sv
// package: constants, register map and enums for the bit-plane pattern sequencer
package bps_pkg;
  // clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int VBP_MIN_US = 370;
  localparam int VBP_MIN_CYC = (VBP_MIN_US * (CLK_HZ / 1_000_000));
  localparam int HSYNC_MIN_PIX = 16;
  localparam int HBP_MIN_PIX = 10;
  localparam int HBLANK_MIN_PIX = 80;
  // geometry
  localparam int PIX_W = 30;
  localparam int PLANE_W = 64;
  localparam int PLANE_IDX_W = 6;
  localparam int PAT_IDX_W = 9;
  localparam int PAT_MAX = 400;
  localparam int WEIGHT_W = 12;
  localparam int UNIT_W = 16;
  localparam int SEQ_LEN_W = 4;
  // axi
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_UNIT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PCOUNT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_ITRIG = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_PATSEL = 8'h10;
  localparam logic [ADDR_W-1:0] REG_PATDATA = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] REG_PIXFMT = 8'h1c;
  // ctrl fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_INTTRIG = 2;
  localparam int CTRL_DEPTH_LO = 4;
  localparam int CTRL_SEQ_LO = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0380;
  localparam logic [UNIT_W-1:0] UNIT_RST = 16'h000a;
  localparam logic [31:0] ITRIG_RST = 32'h0000_1000;
  typedef enum logic [1:0] {
    BPS_MODE_VIDEO = 2'b00,
    BPS_MODE_STORED = 2'b01
  } bps_mode_t;
  typedef enum logic [2:0] {
    BPS_ST_IDLE = 3'b000,
    BPS_ST_LOAD = 3'b001,
    BPS_ST_SHOW = 3'b010,
    BPS_ST_GAP = 3'b011,
    BPS_ST_WAIT = 3'b100
  } bps_state_t;
endpackage

// File: verilog/bps_sync3.sv
// three-stage input synchroniser with agreement filter
module bps_sync3 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // first stage feeds only the second; change accepted when 2 and 3 agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule

// File: verilog/bps_plane_timer.sv
// weighted bit-plane duration timer: base unit times binary weight
module bps_plane_timer
  import bps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic abort,
  input wire logic [UNIT_W-1:0] unit,
  input wire logic [WEIGHT_W-1:0] weight,
  output logic busy,
  output logic done
);
  logic [UNIT_W-1:0] tick_q;
  logic [WEIGHT_W-1:0] left_q;
  // counts unit cycles per weight step; zero unit treated as one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || abort) begin
      tick_q <= '0;
      left_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        left_q <= weight;
        tick_q <= unit;
      end else if (busy) begin
        if (tick_q > UNIT_W'(1)) begin
          tick_q <= tick_q - UNIT_W'(1);
        end else if (left_q > WEIGHT_W'(1)) begin
          left_q <= left_q - WEIGHT_W'(1);
          tick_q <= unit;
        end else begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// File: verilog/bps_sequencer.sv
// bit-plane pattern sequencer top: video and pre-stored pattern modes, axi4-lite regs
// Functional notes
// - accept 16, 20, 24 or 30 bit rgb words up to 120 hz; the code always slices 10-bit colour fields and pixfmt_q is only stored and read back.
// - frame splits into three equal colour slots, red, green, blue.
// - each colour slot splits into one plane per bit, depth 8 to 10.
// - plane time proportional to binary weight; eight planes span 255 units.
// - during a plane only mirrors with that pixel bit set are on.
// - 24-bit frame yields 24 planes held internally, sent one at a time.
// - video display reorders and interleaves planes instead of strict sequence.
// - dual controllers each drive half array, two pixels per clock, native only; the code captures one pixel per pixel clock.
// - sequential pattern modes accept up to 24 bits per pixel into slots.
// - load up to 400 binary patterns into memory, then stream them fast.
// - video pattern mode uses vertical sync to start each sequence.
// - stored mode advances on internal trigger or advance trigger pulse.
// - run gate high starts or continues stored sequence, low stops it.
// - gate fall stops pattern; gate rise re-shows that pattern from start.
// - exposure output high exactly during each displayed pattern's exposure.
// - sequence start output marks the beginning of every new sequence.
// - rgb pattern shown as three colour sub-patterns, each framed.
module bps_sequencer
  import bps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pix_clk,
  input wire logic vsync_in,
  input wire logic de_in,
  input wire logic [PIX_W-1:0] pix_data,
  input wire logic advance_trigger_in,
  input wire logic run_gate_in,
  output logic [PLANE_W-1:0] mirror_row,
  output logic mirror_load,
  output logic exposure_frame_out,
  output logic sequence_start_out
);
  // synchronised pins
  logic pclk_s, vs_s, de_s, adv_s, gate_s;
  logic pclk_prev_q, vs_prev_q, adv_prev_q, gate_prev_q;
  logic pclk_rise, vs_rise, adv_rise, gate_fall;
  bps_sync3 u_sync_pclk (.aclk(aclk), .aresetn(aresetn), .din(pix_clk), .dout(pclk_s));
  bps_sync3 u_sync_vs (.aclk(aclk), .aresetn(aresetn), .din(vsync_in), .dout(vs_s));
  bps_sync3 u_sync_de (.aclk(aclk), .aresetn(aresetn), .din(de_in), .dout(de_s));
  bps_sync3 u_sync_adv (.aclk(aclk), .aresetn(aresetn), .din(advance_trigger_in), .dout(adv_s));
  bps_sync3 u_sync_gate (.aclk(aclk), .aresetn(aresetn), .din(run_gate_in), .dout(gate_s));

  // edge finders on filtered pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pclk_prev_q <= 1'b0;
      vs_prev_q <= 1'b0;
      adv_prev_q <= 1'b0;
      gate_prev_q <= 1'b0;
    end else begin
      pclk_prev_q <= pclk_s;
      vs_prev_q <= vs_s;
      adv_prev_q <= adv_s;
      gate_prev_q <= gate_s;
    end
  end
  assign pclk_rise = pclk_s & ~pclk_prev_q;
  assign vs_rise = vs_s & ~vs_prev_q;
  assign adv_rise = adv_s & ~adv_prev_q;
  assign gate_fall = ~gate_s & gate_prev_q;

  // registers
  logic [31:0] ctrl_q;
  logic [UNIT_W-1:0] unit_q;
  logic [PAT_IDX_W-1:0] pcount_q;
  logic [31:0] itrig_q;
  logic [PAT_IDX_W-1:0] patsel_q;
  logic [1:0] pixfmt_q;
  logic [PLANE_W-1:0] pat_mem [PAT_MAX];
  logic aw_hold_q, w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wr_go;
  assign wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;

  // axi write: address and data accepted in any order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > REG_PIXFMT || awaddr_q == REG_STATUS) ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register stores; any nonzero strobe writes the whole word for simplicity of fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      unit_q <= UNIT_RST;
      pcount_q <= PAT_IDX_W'(1);
      itrig_q <= ITRIG_RST;
      patsel_q <= '0;
      pixfmt_q <= 2'h2;
    end else if (wr_go && s_axi_wstrb != 4'h0) begin
      unique case (awaddr_q)
        REG_CTRL: ctrl_q <= wdata_q;
        REG_UNIT: unit_q <= wdata_q[UNIT_W-1:0];
        REG_PCOUNT: pcount_q <= wdata_q[PAT_IDX_W-1:0];
        REG_ITRIG: itrig_q <= wdata_q;
        REG_PATSEL: patsel_q <= wdata_q[PAT_IDX_W-1:0];
        REG_PIXFMT: pixfmt_q <= wdata_q[1:0];
        default: ;
      endcase
    end
  end

  // pattern memory: each write fills one 64-mirror binary pattern half-word
  logic pat_half_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pat_half_q <= 1'b0;
    end else if (wr_go && awaddr_q == REG_PATDATA && patsel_q < PAT_IDX_W'(PAT_MAX)) begin
      if (pat_half_q) begin
        pat_mem[patsel_q][PLANE_W-1:32] <= wdata_q;
      end else begin
        pat_mem[patsel_q][31:0] <= wdata_q;
      end
      pat_half_q <= ~pat_half_q;
    end else if (wr_go && awaddr_q == REG_PATSEL) begin
      pat_half_q <= 1'b0;
    end
  end

  // video capture: one pixel per pixel clock into a line of planes
  logic [PIX_W-1:0] line_mem [PLANE_W];
  logic [PLANE_IDX_W-1:0] wr_col_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_col_q <= '0;
      // cleared so a plane shown before the first active line is never unknown
      for (int i = 0; i < PLANE_W; i++) begin
        line_mem[i] <= '0;
      end
    end else if (vs_rise || !de_s) begin
      wr_col_q <= '0;
    end else if (pclk_rise) begin
      // one pixel per column: this block fills all 64 columns of the mirror row
      line_mem[wr_col_q] <= pix_data;
      wr_col_q <= wr_col_q + PLANE_IDX_W'(1);
    end
  end

  // sequencer
  bps_state_t state_q;
  logic mode_stored;
  logic enable;
  logic [3:0] depth;
  logic [1:0] color_q;
  logic [3:0] bit_q;
  logic [PAT_IDX_W-1:0] pat_q;
  logic [SEQ_LEN_W-1:0] seq_pos_q;
  logic [31:0] itrig_cnt_q;
  logic tmr_start, tmr_abort, tmr_busy, tmr_done;
  logic [WEIGHT_W-1:0] weight;
  logic adv_evt;
  logic int_tick;
  assign mode_stored = ctrl_q[CTRL_MODE];
  assign enable = ctrl_q[CTRL_EN];
  assign depth = ctrl_q[CTRL_DEPTH_LO +: 4];
  // video plane weight doubles per bit; stored patterns show with unit weight
  assign weight = mode_stored ? WEIGHT_W'(1) : (WEIGHT_W'(1) << bit_q);
  assign tmr_abort = (state_q == BPS_ST_SHOW) && mode_stored && gate_fall;
  assign tmr_start = (state_q == BPS_ST_LOAD);

  bps_plane_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(tmr_start),
    .abort(tmr_abort),
    .unit(unit_q),
    .weight(weight),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // internal configurable trigger
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      itrig_cnt_q <= '0;
    end else if (itrig_cnt_q >= itrig_q) begin
      itrig_cnt_q <= '0;
    end else begin
      itrig_cnt_q <= itrig_cnt_q + 32'h1;
    end
  end
  assign int_tick = (itrig_cnt_q >= itrig_q);
  assign adv_evt = ctrl_q[CTRL_INTTRIG] ? int_tick : adv_rise;

  // bit-plane sequencing: video walks colour slots then planes; stored walks patterns
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      state_q <= BPS_ST_IDLE;
      color_q <= '0;
      bit_q <= '0;
      pat_q <= '0;
      seq_pos_q <= '0;
    end else begin
      unique case (state_q)
        BPS_ST_IDLE: begin
          color_q <= '0;
          bit_q <= '0;
          seq_pos_q <= '0;
          if (!mode_stored && vs_rise) begin
            state_q <= BPS_ST_LOAD;
          end else if (mode_stored && gate_s) begin
            state_q <= BPS_ST_LOAD;
          end
        end
        BPS_ST_LOAD: state_q <= BPS_ST_SHOW;
        BPS_ST_SHOW: begin
          if (tmr_abort) begin
            state_q <= BPS_ST_WAIT;
          end else if (tmr_done) begin
            if (!mode_stored) begin
              // colour slot first, then bit: interleaves colour fields
              if (color_q != 2'h2) begin
                color_q <= color_q + 2'h1;
                state_q <= BPS_ST_LOAD;
              end else if (bit_q + 4'h1 < depth) begin
                color_q <= '0;
                bit_q <= bit_q + 4'h1;
                state_q <= BPS_ST_LOAD;
              end else begin
                state_q <= BPS_ST_IDLE;
              end
            end else begin
              state_q <= BPS_ST_GAP;
            end
          end
        end
        BPS_ST_GAP: begin
          if (!gate_s) begin
            state_q <= BPS_ST_WAIT;
          end else if (adv_evt) begin
            pat_q <= (pat_q + PAT_IDX_W'(1) >= pcount_q) ? '0 : pat_q + PAT_IDX_W'(1);
            seq_pos_q <= (seq_pos_q + SEQ_LEN_W'(1) >= ctrl_q[CTRL_SEQ_LO +: SEQ_LEN_W]) ?
              '0 : seq_pos_q + SEQ_LEN_W'(1);
            state_q <= BPS_ST_LOAD;
          end
        end
        BPS_ST_WAIT: begin
          if (gate_s) begin
            state_q <= BPS_ST_LOAD;
          end
        end
        default: state_q <= BPS_ST_IDLE;
      endcase
    end
  end

  // plane extraction: mirror on only where pixel bit is set
  logic [PLANE_W-1:0] plane_bits;
  logic [4:0] bitpos;
  always_comb begin
    bitpos = 5'(32'(color_q) * 10 + 32'(bit_q));
    for (int i = 0; i < PLANE_W; i++) begin
      plane_bits[i] = line_mem[i][bitpos];
    end
  end

  // mirror outputs and triggers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mirror_row <= '0;
      mirror_load <= 1'b0;
      exposure_frame_out <= 1'b0;
      sequence_start_out <= 1'b0;
    end else begin
      mirror_load <= tmr_start;
      if (tmr_start) begin
        mirror_row <= mode_stored ? pat_mem[pat_q] : plane_bits;
      end
      exposure_frame_out <= tmr_busy && !tmr_abort;
      sequence_start_out <= tmr_start && (mode_stored ? (seq_pos_q == '0) :
        (color_q == '0 && bit_q == '0));
    end
  end

  // axi read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= ctrl_q;
        REG_UNIT: s_axi_rdata <= 32'(unit_q);
        REG_PCOUNT: s_axi_rdata <= 32'(pcount_q);
        REG_ITRIG: s_axi_rdata <= itrig_q;
        REG_PATSEL: s_axi_rdata <= 32'(patsel_q);
        REG_STATUS: s_axi_rdata <= {16'h0, 7'(pat_q), 3'(state_q), 4'(bit_q), color_q};
        REG_PIXFMT: s_axi_rdata <= 32'(pixfmt_q);
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// File: tb/bps_src_model.sv
// video source model: legal blanking, pixel clock only within frames
module bps_src_model
  import bps_pkg::*;
(
  input wire logic run,
  output logic pix_clk,
  output logic vsync_in,
  output logic de_in,
  output logic [PIX_W-1:0] pix_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // per-column pixel word; colours differ so the slot order shows
  function automatic logic [PIX_W-1:0] pix(input int i);
    return {10'(i ^ 32'h2a), ~10'(i), 10'(i)};
  endfunction
  // 144 pixels: 64 active, one per mirror, then 80 blanking with zero front porch
  // data changes 200 ns before the rise and stands 600 ns after it, so the
  // sequencer's late, filtered view of the rise still finds the same word
  task automatic line(input bit act);
    for (int i = 0; i < 144; i++) begin
      #200;
      de_in = act && i < 64;
      pix_data = de_in ? pix(i) : ~pix_data; // released data never holds
      #200 pix_clk = 1'h1;
      #400 pix_clk = 1'h0;
    end
  endtask
  // sync one line, back porch 4 lines (over 370 us), one active line, one front porch line
  initial begin
    pix_clk = 1'h0;
    vsync_in = 1'h0;
    de_in = 1'h0;
    pix_data = '0;
    forever begin
      wait (run === 1'h1);
      // step off the system clock's edges before moving any pin
      #25;
      vsync_in = 1'h1;
      line(0);
      vsync_in = 1'h0;
      repeat (4) line(0);
      line(1);
      line(0);
    end
  end
endmodule

// File: tb/bps_sequencer_monitor.sv
// assertion checker on the sequencer top ports
module bps_sequencer_monitor
  import bps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [PLANE_W-1:0] mirror_row,
  input wire logic mirror_load,
  input wire logic exposure_frame_out,
  input wire logic sequence_start_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // bus takes and refused answers
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_b_err;
    ##[1:2] s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
  endsequence
  a_b_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_b_refused: assert property (s_wr_take ##0 (s_axi_awaddr == REG_STATUS || s_axi_awaddr > REG_PIXFMT) |-> s_b_err)
    else $error("bad write not refused");
  a_ready_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready during response");
  a_r_answer: assert property (s_rd_take |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  a_r_unmapped: assert property (s_rd_take ##0 (s_axi_araddr > REG_PIXFMT)
    |-> ##[1:2] s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_start_pulse: assert property (sequence_start_out |=> !sequence_start_out)
    else $error("start mark too long");
  a_load_pulse: assert property (mirror_load |=> !mirror_load)
    else $error("load pulse too long");
  a_row_steady: assert property ($past(exposure_frame_out) && exposure_frame_out |-> $stable(mirror_row))
    else $error("row changed in exposure");
endmodule
bind bps_sequencer bps_sequencer_monitor mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .mirror_row, .mirror_load, .exposure_frame_out, .sequence_start_out);

// File: tb/bps_sequencer_tb_top.sv
// testbench top: registers, video plane order, stored run and stop
module bps_sequencer_tb_top
  import bps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, run = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, advance_trigger_in = '0, run_gate_in = '0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mirror_load;
  logic exposure_frame_out, sequence_start_out, pix_clk, vsync_in, de_in;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [PIX_W-1:0] pix_data;
  logic [PLANE_W-1:0] mirror_row;
  logic [63:0] pv [3];
  int fails = 0, n_compared = 0, cyc = 0, n_seq = 0;
  bps_sequencer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pix_clk, .vsync_in, .de_in,
    .pix_data, .advance_trigger_in, .run_gate_in, .mirror_row, .mirror_load, .exposure_frame_out,
    .sequence_start_out);
  bps_src_model src (.run, .pix_clk, .vsync_in, .de_in, .pix_data);
  initial begin
    forever #50 aclk = ~aclk;
  end
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one write: address and data offered together, each dropped once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, r);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask
  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
  endtask
  // advance pulse long enough to clear the input filter
  task automatic pulse;
    @(posedge aclk);
    advance_trigger_in <= 1'h1;
    repeat (6) @(posedge aclk);
    advance_trigger_in <= 1'h0;
    @(negedge aclk);
  endtask
  // wait for a load, compare the row, then time its exposure; entered on a falling edge
  task automatic show(input logic [63:0] e, input int len);
    int n;
    n = 0;
    while (mirror_load !== 1'h1) @(negedge aclk);
    chk(mirror_row, e);
    while (exposure_frame_out !== 1'h1) @(negedge aclk);
    while (exposure_frame_out === 1'h1) begin
      n++;
      @(negedge aclk);
    end
    chk(n, len);
  endtask
  function automatic logic [63:0] row(input int c, input int b);
    logic [PIX_W-1:0] p;
    for (int i = 0; i < 64; i++) begin
      p = src.pix(i);
      row[i] = p[c * 10 + b];
    end
  endfunction
  // cycle ceiling well above the expected run of about 11000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (sequence_start_out === 1'h1) n_seq <= n_seq + 1;
    if (cyc == 40000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    int s0;
    rst();
    rd(REG_CTRL, CTRL_RST, RESP_OKAY);
    rd(REG_UNIT, 32'(UNIT_RST), RESP_OKAY);
    rd(REG_PCOUNT, 32'h1, RESP_OKAY);
    rd(REG_ITRIG, ITRIG_RST, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(REG_STATUS, 32'hffff_ffff, RESP_SLVERR);
    wr(8'h24, 32'h1, RESP_SLVERR);
    wr(REG_UNIT, 32'h2, RESP_OKAY);
    rd(REG_UNIT, 32'h2, RESP_OKAY);
    // video mode: second frame shows the first frame's line, weighted planes
    wr(REG_CTRL, 32'h381, RESP_OKAY);
    run <= 1'h1;
    repeat (2) begin
      @(negedge aclk);
      while (sequence_start_out !== 1'h1) @(negedge aclk);
    end
    for (int b = 0; b < 8; b++) begin
      for (int c = 0; c < 3; c++) begin
        show(row(c, b), 2 << b);
      end
    end
    @(posedge aclk);
    run <= 1'h0;
    // stored mode: three patterns, gate dropped mid-exposure of the second
    rst();
    wr(REG_UNIT, 32'hc8, RESP_OKAY);
    wr(REG_PCOUNT, 32'h3, RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      pv[k] = {32'hc3c3_0000 ^ 32'(k), 32'h0f0f_5a5a ^ 32'(k)};
      wr(REG_PATSEL, 32'(k), RESP_OKAY);
      wr(REG_PATDATA, pv[k][31:0], RESP_OKAY);
      wr(REG_PATDATA, pv[k][63:32], RESP_OKAY);
    end
    wr(REG_CTRL, 32'h383, RESP_OKAY);
    s0 = n_seq;
    run_gate_in <= 1'h1;
    @(negedge aclk);
    show(pv[0], 200);
    pulse();
    while (exposure_frame_out !== 1'h1) @(negedge aclk);
    repeat (20) @(negedge aclk);
    @(posedge aclk);
    run_gate_in <= 1'h0;
    repeat (8) @(negedge aclk);
    chk(exposure_frame_out, 1'h0);
    @(posedge aclk);
    run_gate_in <= 1'h1;
    @(negedge aclk);
    show(pv[1], 200);
    pulse();
    show(pv[2], 200);
    pulse();
    show(pv[0], 200);
    chk(n_seq - s0, 2);
    stop_test();
  end
endmodule
